// [rtl/cdsp_cfg.svh]
`ifndef CDSP_CFG_SVH
`define CDSP_CFG_SVH

// register byte offsets
`define CDSP_A_CTRL       8'h00
`define CDSP_A_STATUS     8'h04
`define CDSP_A_IRQ_STAT   8'h08
`define CDSP_A_IRQ_MASK   8'h0C
`define CDSP_A_COMM_TX    8'h10
`define CDSP_A_COMM_RX    8'h14

// watch unit windows: adr[7:5] selects unit, adr[4:2] the word
`define CDSP_UNIT_MSB     7
`define CDSP_UNIT_LSB     5
`define CDSP_WORD_MSB     4
`define CDSP_WORD_LSB     2
`define CDSP_UNIT_BASE    3'h1
`define CDSP_UNIT_LAST    3'h2
`define CDSP_W_ADDR       3'h0
`define CDSP_W_AMASK      3'h1
`define CDSP_W_DATA       3'h2
`define CDSP_W_DMASK      3'h3
`define CDSP_W_CTRL       3'h4

// control register bits
`define CDSP_CTRL_HALT    1
`define CDSP_CTRL_RESUME  2

// status register bits
`define CDSP_ST_ACK       0
`define CDSP_ST_RX_FULL   1
`define CDSP_ST_TX_EMPTY  2
`define CDSP_ST_IHALT     3
`define CDSP_ST_MATCH0    4
`define CDSP_ST_MATCH1    5
`define CDSP_ST_FEAT      6
`define CDSP_ST_RUN_STATE 8

// interrupt events
`define CDSP_EV_W         5
`define CDSP_EV_DEBUG     0
`define CDSP_EV_RX_IN     1
`define CDSP_EV_TX_OUT    2
`define CDSP_EV_MATCH0    3
`define CDSP_EV_MATCH1    4

// synchronised pin vector
`define CDSP_PIN_W        8
`define CDSP_PIN_HALT     0
`define CDSP_PIN_DWATCH   1
`define CDSP_PIN_IBRK     2
`define CDSP_PIN_EXT0     3
`define CDSP_PIN_EXT1     4
`define CDSP_PIN_FEAT     5
`define CDSP_PIN_FLOAT_N  6
`define CDSP_PIN_UNIDIR   7

// watch control word fields
`define CDSP_WC_VAL_LSB   0
`define CDSP_WC_MSK_LSB   4
`define CDSP_WC_EXT_USE   8
`define CDSP_WC_EXT_VAL   9
`define CDSP_WC_EN        31

// timing
`define CDSP_SAMPLE_LAG   3
`define CDSP_MARK_STAGES  2

// reset values
`define CDSP_RST_ONE      1'b1

`endif

// [rtl/cdsp_debug_port.sv]
// Notes on behaviour
// - rx flag high while unread data waits
// - tx flag high while transmit buffer empty
// - debug acknowledge high exactly in debug state
// - enable input low disables debug features
// - internal halt request output reflects external halt pin or control halt bit
// - data watch after data request enters debug
// - external halt enters debug after current instruction
// - condition inputs feed watch units 0 and 1
// - instruction break marks, halts only at execute
// - executed flag follows previous executed instruction
// - match outputs follow unit comparison on buses
// - match outputs ignore watch enable bit
// - bus float low releases memory interface outputs
// - unidirectional mode ignores bus float input
// - unidirectional mode drives all outputs permanently
//
// The Wishbone slave port and the address map are this design's own decisions.
`include "cdsp_cfg.svh"
`default_nettype none

module cdsp_debug_port (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      irq_o,
  // pins from the debug hardware, asynchronous
  input  wire logic                 external_halt_request_i,
  input  wire logic                 data_watch_halt_i,
  input  wire logic                 instr_break_halt_i,
  input  wire logic                 watch_cond_in0_i,
  input  wire logic                 watch_cond_in1_i,
  input  wire logic                 debug_features_on_i,
  input  wire logic                 bus_float_n_i,
  input  wire logic                 unidir_outputs_mode_i,
  // core pipeline, same clock
  input  wire logic                 core_data_req_i,
  input  wire logic                 core_instr_req_i,
  input  wire logic                 core_pipe_adv_i,
  input  wire logic                 core_flush_i,
  input  wire logic                 core_exec_valid_i,
  input  wire logic                 core_exec_pass_i,
  input  wire logic                 core_instr_done_i,
  input  wire cdsp_pkg::cdsp_bus_t  core_bus_i,
  input  wire logic                 core_d_addr_en_i,
  input  wire logic                 core_d_data_en_i,
  input  wire logic                 core_i_addr_en_i,
  // comms channel, debugger side, same clock
  input  wire cdsp_pkg::cdsp_comm_t host_rx_i,
  input  wire logic                 host_tx_read_i,
  output logic      [31:0]          host_tx_data_o,
  // debug outputs
  output logic                      comms_rx_full_o,
  output logic                      comms_tx_empty_o,
  output logic                      debug_state_ack_o,
  output logic                      internal_halt_request_o,
  output logic                      instr_executed_flag_o,
  output logic                      watch_match0_o,
  output logic                      watch_match1_o,
  output logic                      d_addr_oe_n_o,
  output logic                      d_data_oe_n_o,
  output logic                      i_addr_oe_n_o
);

  cdsp_pkg::cdsp_state_t s;
  cdsp_pkg::cdsp_state_t n;

  logic [`CDSP_PIN_W-1:0] pins_raw;
  logic [`CDSP_PIN_W-1:0] pin;
  logic                   feat;
  logic                   uni;
  logic                   acc;
  logic                   wr;
  logic                   rd;
  logic                   resume;
  logic                   watch_hit;
  logic                   wu;
  logic                   rx_take;
  logic                   rx_drain;
  logic                   tx_load;
  logic                   tx_take;
  logic                   dw_hit;
  logic                   ib_sample;
  logic                   ib_hit;
  logic                   wp_hit;
  logic [1:0]             unit_match;
  logic [1:0]             unit_armed;
  logic [`CDSP_EV_W-1:0]  ev;
  logic [`CDSP_EV_W-1:0]  clr;
  logic [31:0]            status_word;
  logic [31:0]            rword;
  logic [31:0]            imask_word;

  // byte-lane merge of a wishbone write
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] watch_word(input cdsp_pkg::cdsp_watch_cfg_t c,
                                             input logic [2:0]                idx);
    logic [31:0] r;
    case (idx)
      `CDSP_W_ADDR:  r = c.addr;
      `CDSP_W_AMASK: r = c.amask;
      `CDSP_W_DATA:  r = c.data;
      `CDSP_W_DMASK: r = c.dmask;
      `CDSP_W_CTRL:  r = c.ctrl;
      default:       r = '0;
    endcase
    return r;
  endfunction

  function automatic logic watch_word_ok(input logic [2:0] idx);
    return idx <= `CDSP_W_CTRL;
  endfunction

  assign pins_raw = {unidir_outputs_mode_i, bus_float_n_i, debug_features_on_i,
                     watch_cond_in1_i, watch_cond_in0_i, instr_break_halt_i,
                     data_watch_halt_i, external_halt_request_i};

  // only the second synchroniser stage is read by logic
  assign pin  = s.sync2;
  assign feat = pin[`CDSP_PIN_FEAT];
  assign uni  = pin[`CDSP_PIN_UNIDIR];

  // bus access decode; the access acts on the edge that raises ack
  assign acc = wb_cyc_i & wb_stb_i & ~s.wb_ack;
  assign wr  = acc & wb_we_i;
  assign rd  = acc & ~wb_we_i;

  assign resume = wr & (wb_adr_i == `CDSP_A_CTRL) & wb_sel_i[0] & wb_dat_i[`CDSP_CTRL_RESUME];

  assign watch_hit = (wb_adr_i[`CDSP_UNIT_MSB:`CDSP_UNIT_LSB] == `CDSP_UNIT_BASE
                      || wb_adr_i[`CDSP_UNIT_MSB:`CDSP_UNIT_LSB] == `CDSP_UNIT_LAST)
                     && watch_word_ok(wb_adr_i[`CDSP_WORD_MSB:`CDSP_WORD_LSB]);
  assign wu = wb_adr_i[`CDSP_UNIT_LSB+1];
  assign imask_word = merge(32'(s.imask), wb_dat_i, wb_sel_i);

  // comms buffers, one word each way
  assign rx_take  = host_rx_i.valid & ~s.rx_full;
  assign rx_drain = rd & (wb_adr_i == `CDSP_A_COMM_RX) & s.rx_full;
  assign tx_load  = wr & (wb_adr_i == `CDSP_A_COMM_TX) & s.tx_empty;
  assign tx_take  = host_tx_read_i & ~s.tx_empty;

  // request delayed to line up with the synchronised pin of the following cycle
  assign dw_hit    = s.req_d[`CDSP_SAMPLE_LAG-1] & pin[`CDSP_PIN_DWATCH];
  assign ib_sample = s.ireq_d[`CDSP_SAMPLE_LAG-1] & pin[`CDSP_PIN_IBRK];
  assign ib_hit    = s.marks[`CDSP_MARK_STAGES-1] & core_exec_valid_i;
  assign wp_hit    = |s.armed;

  for (genvar g = 0; g < 2; g++) begin : g_unit
    cdsp_watch_unit u_watch (
      .cfg_i   (s.watch[g]),
      .bus_i   (core_bus_i),
      .cond_i  (pin[`CDSP_PIN_EXT0+g]),
      .match_o (unit_match[g]),
      .armed_o (unit_armed[g])
    );
  end

  always_comb begin
    status_word = '0;
    status_word[`CDSP_ST_ACK]      = s.ack_dbg;
    status_word[`CDSP_ST_RX_FULL]  = s.rx_full;
    status_word[`CDSP_ST_TX_EMPTY] = s.tx_empty;
    status_word[`CDSP_ST_IHALT]    = s.ihalt;
    status_word[`CDSP_ST_MATCH0]   = s.match[0];
    status_word[`CDSP_ST_MATCH1]   = s.match[1];
    status_word[`CDSP_ST_FEAT]     = feat;
    status_word[`CDSP_ST_RUN_STATE +: 2] = s.st;
  end

  always_comb begin
    case (wb_adr_i)
      `CDSP_A_CTRL:     rword = s.ctrl;
      `CDSP_A_STATUS:   rword = status_word;
      `CDSP_A_IRQ_STAT: rword = 32'(s.istat);
      `CDSP_A_IRQ_MASK: rword = 32'(s.imask);
      `CDSP_A_COMM_TX:  rword = s.tx_data;
      `CDSP_A_COMM_RX:  rword = s.rx_data;
      default: begin
        if (watch_hit) begin
          rword = watch_word(s.watch[wu], wb_adr_i[`CDSP_WORD_MSB:`CDSP_WORD_LSB]);
        end else begin
          rword = '0;
        end
      end
    endcase
  end

  // interrupt events
  always_comb begin
    ev = '0;
    ev[`CDSP_EV_DEBUG]  = (n.st == cdsp_pkg::cdsp_st_debug) & (s.st != cdsp_pkg::cdsp_st_debug);
    ev[`CDSP_EV_RX_IN]  = rx_take;
    ev[`CDSP_EV_TX_OUT] = tx_take;
    ev[`CDSP_EV_MATCH0] = unit_match[0] & ~s.match[0];
    ev[`CDSP_EV_MATCH1] = unit_match[1] & ~s.match[1];
    clr = (rd && wb_adr_i == `CDSP_A_IRQ_STAT) ? s.istat : '0;
  end

  always_comb begin
    n = s;
    n.sync1  = pins_raw;
    n.sync2  = s.sync1;
    n.wb_ack = acc;
    n.wb_dat = rd ? rword : '0;

    // software registers
    if (wr && wb_adr_i == `CDSP_A_CTRL) begin
      n.ctrl = merge(s.ctrl, wb_dat_i, wb_sel_i);
    end
    n.ctrl[`CDSP_CTRL_RESUME] = 1'b0;
    if (wr && wb_adr_i == `CDSP_A_IRQ_MASK) begin
      n.imask = imask_word[`CDSP_EV_W-1:0];
    end
    if (wr && watch_hit) begin
      case (wb_adr_i[`CDSP_WORD_MSB:`CDSP_WORD_LSB])
        `CDSP_W_ADDR:  n.watch[wu].addr  = merge(s.watch[wu].addr, wb_dat_i, wb_sel_i);
        `CDSP_W_AMASK: n.watch[wu].amask = merge(s.watch[wu].amask, wb_dat_i, wb_sel_i);
        `CDSP_W_DATA:  n.watch[wu].data  = merge(s.watch[wu].data, wb_dat_i, wb_sel_i);
        `CDSP_W_DMASK: n.watch[wu].dmask = merge(s.watch[wu].dmask, wb_dat_i, wb_sel_i);
        `CDSP_W_CTRL:  n.watch[wu].ctrl  = merge(s.watch[wu].ctrl, wb_dat_i, wb_sel_i);
        default:       n.watch[wu].ctrl  = s.watch[wu].ctrl;
      endcase
    end

    // comms channel: a full rx refuses the host, a full tx refuses software
    if (rx_take) begin
      n.rx_full = 1'b1;
      n.rx_data = host_rx_i.data;
    end else if (rx_drain) begin
      n.rx_full = 1'b0;
    end
    if (tx_load) begin
      n.tx_empty = 1'b0;
      n.tx_data  = merge(s.tx_data, wb_dat_i, wb_sel_i);
    end else if (tx_take) begin
      n.tx_empty = 1'b1;
    end

    // breakpoint marks travel with the instruction; a flush drops them
    n.req_d  = {s.req_d[`CDSP_SAMPLE_LAG-2:0], core_data_req_i};
    n.ireq_d = {s.ireq_d[`CDSP_SAMPLE_LAG-2:0], core_instr_req_i};
    if (core_flush_i) begin
      n.marks = '0;
    end else if (core_pipe_adv_i) begin
      n.marks = {s.marks[`CDSP_MARK_STAGES-2:0], ib_sample};
    end else begin
      n.marks[0] = s.marks[0] | ib_sample;
    end

    n.ihalt = feat & (pin[`CDSP_PIN_HALT] | s.ctrl[`CDSP_CTRL_HALT]);

    // disabled features also throw the core out of debug state
    case (s.st)
      cdsp_pkg::cdsp_st_run: begin
        if (feat && (dw_hit || ib_hit || wp_hit)) begin
          n.st = cdsp_pkg::cdsp_st_debug;
        end else if (feat && s.ihalt) begin
          n.st = cdsp_pkg::cdsp_st_wait;
        end
      end
      cdsp_pkg::cdsp_st_wait: begin
        if (!feat) begin
          n.st = cdsp_pkg::cdsp_st_run;
        end else if (core_instr_done_i || dw_hit || ib_hit || wp_hit) begin
          n.st = cdsp_pkg::cdsp_st_debug;
        end
      end
      cdsp_pkg::cdsp_st_debug: begin
        if (!feat || resume) begin
          n.st = cdsp_pkg::cdsp_st_run;
        end
      end
      default: n.st = cdsp_pkg::cdsp_st_run;
    endcase
    n.ack_dbg = (n.st == cdsp_pkg::cdsp_st_debug);

    n.iexec = core_exec_valid_i & core_exec_pass_i;
    n.match = unit_match;
    n.armed = unit_armed;

    // set wins over the read clear
    n.istat = (s.istat & ~clr) | ev;
    n.irq   = |(n.istat & n.imask);

    // enables low means driving; unidirectional mode drives everything
    n.oe_d_addr_n = ~(uni | (pin[`CDSP_PIN_FLOAT_N] & core_d_addr_en_i));
    n.oe_d_data_n = ~(uni | (pin[`CDSP_PIN_FLOAT_N] & core_d_data_en_i));
    n.oe_i_addr_n = ~(uni | (pin[`CDSP_PIN_FLOAT_N] & core_i_addr_en_i));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s             <= '0;
      s.tx_empty    <= `CDSP_RST_ONE;
      s.oe_d_addr_n <= `CDSP_RST_ONE;
      s.oe_d_data_n <= `CDSP_RST_ONE;
      s.oe_i_addr_n <= `CDSP_RST_ONE;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o                = s.wb_dat;
  assign wb_ack_o                = s.wb_ack;
  assign irq_o                   = s.irq;
  assign host_tx_data_o          = s.tx_data;
  assign comms_rx_full_o         = s.rx_full;
  assign comms_tx_empty_o        = s.tx_empty;
  assign debug_state_ack_o       = s.ack_dbg;
  assign internal_halt_request_o = s.ihalt;
  assign instr_executed_flag_o   = s.iexec;
  assign watch_match0_o          = s.match[0];
  assign watch_match1_o          = s.match[1];
  assign d_addr_oe_n_o           = s.oe_d_addr_n;
  assign d_data_oe_n_o           = s.oe_d_data_n;
  assign i_addr_oe_n_o           = s.oe_i_addr_n;

endmodule // cdsp_debug_port

`default_nettype wire

// [rtl/cdsp_pkg.sv]
`default_nettype none

package cdsp_pkg;

  typedef enum logic [1:0] {
    cdsp_st_run,
    cdsp_st_wait,
    cdsp_st_debug
  } cdsp_dbg_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  ctrl;
  } cdsp_bus_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] amask;
    logic [31:0] data;
    logic [31:0] dmask;
    logic [31:0] ctrl;
  } cdsp_watch_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } cdsp_comm_t;

  typedef struct packed {
    logic [7:0]                 sync1;
    logic [7:0]                 sync2;
    logic                       wb_ack;
    logic [31:0]                wb_dat;
    logic [31:0]                ctrl;
    logic [4:0]                 imask;
    logic [4:0]                 istat;
    logic                       irq;
    logic [31:0]                tx_data;
    logic [31:0]                rx_data;
    logic                       rx_full;
    logic                       tx_empty;
    cdsp_watch_cfg_t [1:0]      watch;
    cdsp_dbg_state_t            st;
    logic [2:0]                 req_d;
    logic [2:0]                 ireq_d;
    logic [1:0]                 marks;
    logic [1:0]                 match;
    logic [1:0]                 armed;
    logic                       ack_dbg;
    logic                       ihalt;
    logic                       iexec;
    logic                       oe_d_addr_n;
    logic                       oe_d_data_n;
    logic                       oe_i_addr_n;
  } cdsp_state_t;

endpackage

`default_nettype wire

// [rtl/cdsp_watch_unit.sv]
`include "cdsp_cfg.svh"
`default_nettype none

module cdsp_watch_unit (
  input  wire cdsp_pkg::cdsp_watch_cfg_t cfg_i,
  input  wire cdsp_pkg::cdsp_bus_t       bus_i,
  input  wire logic                      cond_i,
  output logic                           match_o,
  output logic                           armed_o
);

  logic [3:0] ctrl_val;
  logic [3:0] ctrl_msk;
  logic       addr_ok;
  logic       data_ok;
  logic       ctrl_ok;
  logic       cond_ok;

  // mask bit set means the bit is a don't-care
  assign ctrl_val = cfg_i.ctrl[`CDSP_WC_VAL_LSB +: 4];
  assign ctrl_msk = cfg_i.ctrl[`CDSP_WC_MSK_LSB +: 4];
  assign addr_ok  = ((bus_i.addr ^ cfg_i.addr) & ~cfg_i.amask) == '0;
  assign data_ok  = ((bus_i.data ^ cfg_i.data) & ~cfg_i.dmask) == '0;
  assign ctrl_ok  = ((bus_i.ctrl ^ ctrl_val) & ~ctrl_msk) == '0;
  assign cond_ok  = ~cfg_i.ctrl[`CDSP_WC_EXT_USE] | (cond_i == cfg_i.ctrl[`CDSP_WC_EXT_VAL]);

  // match does not look at the enable bit
  assign match_o  = addr_ok & data_ok & ctrl_ok & cond_ok;
  assign armed_o  = match_o & cfg_i.ctrl[`CDSP_WC_EN];

endmodule // cdsp_watch_unit

`default_nettype wire

// [testbench/cdsp_dbg_host.sv]
`default_nettype none

module cdsp_dbg_host (
  input  wire logic            clk_i,
  input  wire logic            rx_full_i,
  input  wire logic            tx_empty_i,
  input  wire logic [31:0]     tx_data_i,
  output logic      [7:0]      pins_o,
  output cdsp_pkg::cdsp_comm_t rx_o,
  output logic                 tx_read_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins: halt, data watch, instr break, cond0, cond1, enable, float_n, unidir
  initial begin
    pins_o = 8'h60;
    rx_o = '0;
    tx_read_o = 1'b0;
  end

  task automatic set_pins(input logic [7:0] v);
    @(posedge clk_i);
    pins_o <= v;
  endtask

  // push offers even when full, only for the refusal case
  task automatic put_word(input logic [31:0] d, input logic push);
    @(posedge clk_i);
    while (rx_full_i && !push) @(posedge clk_i);
    rx_o <= '{1'b1, d};
    @(posedge clk_i);
    rx_o <= '{1'b0, ~d};
  endtask

  task automatic take_word(output logic [31:0] d);
    @(posedge clk_i);
    while (tx_empty_i) @(posedge clk_i);
    d = tx_data_i;
    tx_read_o <= 1'b1;
    @(posedge clk_i);
    tx_read_o <= 1'b0;
  endtask

endmodule // cdsp_dbg_host

`default_nettype wire

// [testbench/cdsp_debug_port_checker.sv]
`default_nettype none

module cdsp_debug_port_checker (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 external_halt_request_i,
  input wire logic                 debug_features_on_i,
  input wire logic                 bus_float_n_i,
  input wire logic                 unidir_outputs_mode_i,
  input wire logic                 core_exec_valid_i,
  input wire logic                 core_exec_pass_i,
  input wire logic                 core_d_addr_en_i,
  input wire cdsp_pkg::cdsp_comm_t host_rx_i,
  input wire logic                 host_tx_read_i,
  input wire logic                 comms_rx_full_o,
  input wire logic                 comms_tx_empty_o,
  input wire logic                 debug_state_ack_o,
  input wire logic                 internal_halt_request_o,
  input wire logic                 instr_executed_flag_o,
  input wire logic                 d_addr_oe_n_o,
  input wire logic                 d_data_oe_n_o,
  input wire logic                 i_addr_oe_n_o
);
  // pin checks look three cycles back, so wait until that history is post-reset
  logic [2:0] live;
  wire logic  ok = (live == 3'h4);

  always_ff @(posedge clk_i) begin
    if (rst_i) live <= 3'h0;
    else if (live != 3'h4) live <= live + 3'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  exec_flag_a: assert property (
    ok |-> instr_executed_flag_o == $past(core_exec_valid_i & core_exec_pass_i)
  ) else $error("executed flag differs from last cycle");
  halt_or_a: assert property (
    ok && $past(external_halt_request_i, 3) && $past(debug_features_on_i, 3) |-> internal_halt_request_o
  ) else $error("external halt not seen on internal request");
  feat_off_a: assert property (
    ok && !$past(debug_features_on_i, 3) |-> !internal_halt_request_o
  ) else $error("internal request while debug disabled");
  ack_off_a: assert property (
    !debug_features_on_i [*8] |-> !debug_state_ack_o
  ) else $error("debug ack while debug disabled");
  unidir_a: assert property (
    ok && $past(unidir_outputs_mode_i, 3) |-> !d_addr_oe_n_o && !d_data_oe_n_o && !i_addr_oe_n_o
  ) else $error("output released in unidirectional mode");
  float_a: assert property (
    ok && !$past(unidir_outputs_mode_i, 3) && !$past(bus_float_n_i, 3)
    |-> d_addr_oe_n_o && d_data_oe_n_o && i_addr_oe_n_o
  ) else $error("bus driven while float requested");
  drive_a: assert property (
    ok && !$past(unidir_outputs_mode_i, 3) && $past(bus_float_n_i, 3)
    |-> d_addr_oe_n_o == !$past(core_d_addr_en_i)
  ) else $error("address enable does not follow core");
  rx_a: assert property (
    host_rx_i.valid && !comms_rx_full_o |=> comms_rx_full_o
  ) else $error("receive flag not raised");
  tx_a: assert property (
    host_tx_read_i && !comms_tx_empty_o |=> comms_tx_empty_o
  ) else $error("transmit empty flag not raised");

endmodule // cdsp_debug_port_checker

bind cdsp_debug_port cdsp_debug_port_checker chk_u (.clk_i, .rst_i, .external_halt_request_i,
  .debug_features_on_i, .bus_float_n_i, .unidir_outputs_mode_i, .core_exec_valid_i, .core_exec_pass_i,
  .core_d_addr_en_i, .host_rx_i, .host_tx_read_i, .comms_rx_full_o, .comms_tx_empty_o, .debug_state_ack_o,
  .internal_halt_request_o, .instr_executed_flag_o, .d_addr_oe_n_o, .d_data_oe_n_o, .i_addr_oe_n_o);

`default_nettype wire

// [testbench/cdsp_debug_port_test.sv]
`default_nettype none

module cdsp_debug_port_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 cyc = 1'b0;
  logic                 we = 1'b0;
  logic [7:0]           adr = 8'h00;
  logic [31:0]          wdat = 32'h0;
  logic [3:0]           sel = 4'hF;
  logic [31:0]          rdat;
  logic [31:0]          word;
  logic [6:0]           core = 7'h00; // data req, instr req, adv, flush, valid, pass, done
  logic [2:0]           en = 3'h0;
  cdsp_pkg::cdsp_bus_t  bus = '{32'h0000_1000, 32'h0, 4'h0};
  cdsp_pkg::cdsp_comm_t hrx;
  wire logic [7:0]      pins;
  wire logic [31:0]     dat_o;
  wire logic [31:0]     txd;
  wire logic            tx_rd;
  // m1 m0 ack irq rx_full tx_empty dbg_ack ihalt iexec oe_n[2:0]
  wire logic [11:0]     flags;
  int                   err_count = 0;
  int                   total_checks = 0;

  cdsp_debug_port uut (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(flags[9]), .irq_o(flags[8]),
    .external_halt_request_i(pins[0]), .data_watch_halt_i(pins[1]), .instr_break_halt_i(pins[2]),
    .watch_cond_in0_i(pins[3]), .watch_cond_in1_i(pins[4]), .debug_features_on_i(pins[5]),
    .bus_float_n_i(pins[6]), .unidir_outputs_mode_i(pins[7]), .core_data_req_i(core[0]),
    .core_instr_req_i(core[1]), .core_pipe_adv_i(core[2]), .core_flush_i(core[3]),
    .core_exec_valid_i(core[4]), .core_exec_pass_i(core[5]), .core_instr_done_i(core[6]),
    .core_bus_i(bus), .core_d_addr_en_i(en[2]), .core_d_data_en_i(en[1]), .core_i_addr_en_i(en[0]),
    .host_rx_i(hrx), .host_tx_read_i(tx_rd), .host_tx_data_o(txd), .comms_rx_full_o(flags[7]),
    .comms_tx_empty_o(flags[6]), .debug_state_ack_o(flags[5]), .internal_halt_request_o(flags[4]),
    .instr_executed_flag_o(flags[3]), .watch_match0_o(flags[10]), .watch_match1_o(flags[11]),
    .d_addr_oe_n_o(flags[2]), .d_data_oe_n_o(flags[1]), .i_addr_oe_n_o(flags[0]));

  cdsp_dbg_host host (.clk_i, .rx_full_i(flags[7]), .tx_empty_i(flags[6]), .tx_data_i(txd),
    .pins_o(pins), .rx_o(hrx), .tx_read_o(tx_rd));

  initial forever #10 clk_i = ~clk_i;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic fl(input logic [11:0] exp);
    chk({20'h0, flags}, {20'h0, exp});
  endtask

  // wait on ack with no fixed latency; the watchdog bounds it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (flags[9] !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge clk_i);
    core <= core | 7'(1 << i);
    @(posedge clk_i);
    core <= core & ~7'(1 << i);
  endtask

  task automatic end_sim;
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    tick(5000);
    err_count++;
    end_sim();
  end

  initial begin
    tick(4);
    rst_i <= 1'b0;
    tick(4);
    fl(12'h047);
    rd(8'h04, 32'h44);
    rd(8'h0C, 32'h0);
    wb(1'b1, 8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0);
    sel <= 4'h2;
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    sel <= 4'hF;
    rd(8'h00, 32'h0000_FF00);
    wb(1'b1, 8'h00, 32'h0);
    // receive: masked event, refused second word, then unmask and clear
    host.put_word(32'hA5A5_0001, 1'b0);
    tick(2);
    fl(12'h0C7);
    host.put_word(32'h0BAD_0002, 1'b1);
    wb(1'b1, 8'h0C, 32'h2);
    tick(2);
    fl(12'h1C7);
    rd(8'h08, 32'h2);
    tick(2);
    fl(12'h0C7);
    rd(8'h14, 32'hA5A5_0001);
    tick(1);
    fl(12'h047);
    // transmit, with a refused overwrite
    wb(1'b1, 8'h10, 32'h1234_5678);
    tick(1);
    fl(12'h007);
    wb(1'b1, 8'h10, 32'hFFFF_FFFF);
    host.take_word(word);
    chk(word, 32'h1234_5678);
    tick(2);
    fl(12'h047);
    // halt from control bit, then from the pin
    wb(1'b1, 8'h00, 32'h2);
    tick(3);
    fl(12'h057);
    tick(4);
    fl(12'h057);
    pulse(6);
    tick(2);
    fl(12'h077);
    wb(1'b1, 8'h00, 32'h4);
    tick(3);
    fl(12'h047);
    host.set_pins(8'h61);
    tick(4);
    fl(12'h057);
    pulse(6);
    tick(2);
    fl(12'h077);
    host.set_pins(8'h60);
    tick(4);
    wb(1'b1, 8'h00, 32'h4);
    tick(3);
    fl(12'h047);
    // debug disabled: pin and control bit both ignored
    host.set_pins(8'h41);
    wb(1'b1, 8'h00, 32'h2);
    tick(4);
    fl(12'h047);
    pulse(6);
    tick(2);
    fl(12'h047);
    wb(1'b1, 8'h00, 32'h0);
    host.set_pins(8'h60);
    // data watch counts only after a data request
    host.set_pins(8'h62);
    tick(6);
    fl(12'h047);
    pulse(0);
    tick(5);
    fl(12'h067);
    host.set_pins(8'h60);
    wb(1'b1, 8'h00, 32'h4);
    tick(3);
    fl(12'h047);
    // instruction break: flushed mark dies, executed mark halts
    for (int k = 0; k < 2; k++) begin
      host.set_pins(8'h64);
      pulse(1);
      host.set_pins(8'h60);
      tick(3);
      if (k == 0) pulse(3);
      pulse(2);
      fl(12'h047);
      pulse(4);
      tick(2);
      fl(k == 0 ? 12'h047 : 12'h067);
    end
    // a flush drops the fired mark; executed flag then set only for valid with pass, over all four pairs
    pulse(3);
    wb(1'b1, 8'h00, 32'h4);
    tick(3);
    for (int i = 3; i >= 0; i--) begin
      core[5:4] <= 2'(i);
      tick(2);
      fl(i == 3 ? 12'h04F : 12'h047);
    end
    // unit 0 on address, enable bit clear; unit 1 on its condition pin
    wb(1'b1, 8'h20, 32'h0000_1000);
    wb(1'b1, 8'h2C, 32'hFFFF_FFF0);
    wb(1'b1, 8'h30, 32'h0000_00F0);
    tick(2);
    fl(12'h447);
    bus.data <= 32'h3;
    tick(2);
    fl(12'h047);
    bus <= '{32'h0000_1004, 32'h0, 4'h5};
    tick(2);
    fl(12'h047);
    wb(1'b1, 8'h44, 32'hFFFF_FFFF);
    wb(1'b1, 8'h4C, 32'hFFFF_FFFF);
    wb(1'b1, 8'h50, 32'h0000_03F0);
    tick(2);
    fl(12'h047);
    host.set_pins(8'h70);
    tick(4);
    fl(12'h847);
    host.set_pins(8'h68);
    tick(4);
    fl(12'h047);
    // output enables: drive, float, unidirectional override
    en <= 3'h7;
    tick(2);
    fl(12'h040);
    host.set_pins(8'h20);
    tick(4);
    fl(12'h047);
    host.set_pins(8'hA0);
    tick(4);
    fl(12'h040);
    en <= 3'h0;
    tick(2);
    fl(12'h040);
    end_sim();
  end

endmodule // cdsp_debug_port_test

`default_nettype wire
